// *** verilog/erb_pkg.sv ***
// shared constants for the receive buffer manager
// ============================================================
// Summary of operation
// - status bit 30 marks a frame carrying a VLAN tag
// - bit 27 marks a control frame; bit 29 an unknown control opcode
// - bit 28 only for a control frame with pause opcode and pause address
// - bit 26 when 1 to 7 trailing bits arrived; those bits are dropped
// - bit 25 for broadcast and bit 24 for a multicast destination other than broadcast
// - bit 23 only when CRC is good and no symbol error was seen
// - bit 22 when type/length exceeds 1500, meaning a type field
// - bit 21 when a valid length differs from the data bytes received
// - bit 20 when the received CRC disagrees with the computed one
// - bit 18 when idle channel activity was seen since last reception
// - bit 16 after a giant packet or a dropped packet since last reception
// - bits 15-0 hold the whole frame length, little-endian
// - auto-increment advances the read pointer and wraps end to start
// - data bytes never write the release location; a collision aborts and flags error
// - release low byte is held until the high byte loads both
// - decrement request lowers the count, clears pending at zero, floors at 0
// - with count at 255 every new packet is aborted with error flag
// - write pointer moves only when a packet is fully stored or the window start/end is written
// - write pointer never lands on the release pointer
// - each stored packet starts with next pointer and status vector
// - odd end address gets one pad byte so packets start even
// - a stored packet bumps the count, sets pending, moves write pointer
package erb_pkg;
  // ==========================================================
  // register offsets
  localparam logic [3:0] OFF_DATA   = 4'h0;
  localparam logic [3:0] OFF_RDP_LO = 4'h1;
  localparam logic [3:0] OFF_RDP_HI = 4'h2;
  localparam logic [3:0] OFF_ST_LO  = 4'h3;
  localparam logic [3:0] OFF_ST_HI  = 4'h4;
  localparam logic [3:0] OFF_ND_LO  = 4'h5;
  localparam logic [3:0] OFF_ND_HI  = 4'h6;
  localparam logic [3:0] OFF_REL_LO = 4'h7;
  localparam logic [3:0] OFF_REL_HI = 4'h8;
  localparam logic [3:0] OFF_WR_LO  = 4'h9;
  localparam logic [3:0] OFF_WR_HI  = 4'hA;
  localparam logic [3:0] OFF_CNT    = 4'hB;
  localparam logic [3:0] OFF_CTRL2  = 4'hC;
  localparam logic [3:0] OFF_FLAGS  = 4'hD;
  // ==========================================================
  // field positions
  localparam int CTRL_READ_AUTO_INCREMENT_EN_BIT = 7;
  localparam int CTRL_DEC_BIT     = 6;
  localparam int FLAG_PEND_BIT    = 6;
  localparam int FLAG_ERR_BIT     = 0;
  localparam int SV_VLAN   = 30;
  localparam int SV_UNKOP  = 29;
  localparam int SV_PAUSE  = 28;
  localparam int SV_CTRL   = 27;
  localparam int SV_DRIB   = 26;
  localparam int SV_BCAST  = 25;
  localparam int SV_MCAST  = 24;
  localparam int SV_OK     = 23;
  localparam int SV_LOOR   = 22;
  localparam int SV_LCHK   = 21;
  localparam int SV_CRC    = 20;
  localparam int SV_CARR   = 18;
  localparam int SV_LONG   = 16;
  // ==========================================================
  // frame constants
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
  localparam logic [2:0]  HDR_LEN      = 3'h6;
  localparam logic [2:0]  HDR_LAST     = 3'h5;
  localparam logic [15:0] TYPE_VLAN    = 16'h8100;
  localparam logic [15:0] TYPE_CTRL    = 16'h8808;
  localparam logic [15:0] OPC_PAUSE    = 16'h0001;
  localparam logic [15:0] LEN_MAX      = 16'h05DC;
  localparam logic [15:0] FRAME_OVHD   = 16'h0012;
  localparam logic [47:0] PAUSE_DA     = 48'h0180C2000001;
  localparam logic [15:0] IDX_DA_LAST  = 16'h0005;
  localparam logic [15:0] IDX_TYPE_HI  = 16'h000C;
  localparam logic [15:0] IDX_TYPE_LO  = 16'h000D;
  localparam logic [15:0] IDX_OPC_HI   = 16'h000E;
  localparam logic [15:0] IDX_OPC_LO   = 16'h000F;
  localparam logic [7:0]  BYTE_ONES    = 8'hFF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_HDR  = 2'b10,
    ST_DROP = 2'b11
  } erb_state_t;
endpackage : erb_pkg

// *** verilog/erb_rx_buffer.sv ***
// receive packet bookkeeping: status vector, circular buffer, pointers
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
module erb_rx_buffer #(
  parameter int ADDR_W = 13
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        rx_frame_start_in,
  input  wire logic        rx_byte_valid_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_frame_end_in,
  input  wire logic        rx_crc_err_in,
  input  wire logic        rx_symbol_err_in,
  input  wire logic [2:0]  rx_dribble_bits_in,
  input  wire logic        rx_carrier_event_in,
  input  wire logic        rx_long_event_in,
  input  wire logic        rx_drop_in,
  output logic             packet_pending_flag_out,
  output logic             rx_error_flag_out
);
  import erb_pkg::*;

  // elaboration-time refusal of pointer widths the byte split cannot serve
  if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W must lie between 9 and 16");
  end

  typedef logic [ADDR_W-1:0] erb_ptr_t;
  localparam logic [ADDR_W:0] ONE_W = (ADDR_W+1)'(1);

  // ==========================================================
  // pointer arithmetic inside the circular window
  function automatic erb_ptr_t f_inc(erb_ptr_t p, erb_ptr_t st,
                                     erb_ptr_t nd);
    return (p == nd) ? st : erb_ptr_t'(p + erb_ptr_t'(1));
  endfunction : f_inc

  function automatic erb_ptr_t f_add(erb_ptr_t p, logic [2:0] n,
                                     erb_ptr_t st, erb_ptr_t nd);
    logic [ADDR_W:0] s;
    s = {1'b0, p} + (ADDR_W+1)'(n);
    if (s > {1'b0, nd}) begin
      s = s - ({1'b0, nd} - {1'b0, st} + ONE_W);
    end
    return s[ADDR_W-1:0];
  endfunction : f_add

  // distance forward from a to b; zero means equal
  function automatic logic [ADDR_W:0] f_dist(erb_ptr_t a, erb_ptr_t b,
                                             erb_ptr_t st, erb_ptr_t nd);
    logic [ADDR_W:0] d;
    d = {1'b0, b} - {1'b0, a};
    if (b < a) begin
      d = d + ({1'b0, nd} - {1'b0, st} + ONE_W);
    end
    return d;
  endfunction : f_dist

  function automatic logic [7:0] f_hi(erb_ptr_t p);
    logic [15:0] w;
    w = 16'(p);
    return w[15:8];
  endfunction : f_hi

  // ==========================================================
  // storage and registers
  logic [7:0]  mem [0:(1<<ADDR_W)-1];
  erb_ptr_t    rx_start_q, rx_end_q, rdptr_q, rel_q, wp_q;
  logic [7:0]  rel_lo_hold_q;
  logic        read_auto_increment_en_q;
  logic [7:0]  cnt_q, cnt_d;
  logic        pend_q, err_q;
  logic        carr_seen_q, long_seen_q;
  erb_state_t  state_q;
  erb_ptr_t    cur_q, next_ptr_q;
  logic [15:0] bc_q, type_q, opc_q;
  logic        bcast_q, mcast_q, pda_q;
  logic [2:0]  hidx_q;
  logic [31:0] sv_q, sv_d;
  logic [7:0]  rdata_q;

  logic wr_rdp_lo, wr_rdp_hi, wr_st, wr_nd, wr_rel_hi, dec_req, data_rd;
  assign wr_rdp_lo = reg_wr_in && reg_addr_in == OFF_RDP_LO;
  assign wr_rdp_hi = reg_wr_in && reg_addr_in == OFF_RDP_HI;
  assign wr_st     = reg_wr_in && (reg_addr_in == OFF_ST_LO ||
                                   reg_addr_in == OFF_ST_HI);
  assign wr_nd     = reg_wr_in && (reg_addr_in == OFF_ND_LO ||
                                   reg_addr_in == OFF_ND_HI);
  assign wr_rel_hi = reg_wr_in && reg_addr_in == OFF_REL_HI;
  assign dec_req   = reg_wr_in && reg_addr_in == OFF_CTRL2 &&
                     reg_wdata_in[CTRL_DEC_BIT];
  assign data_rd   = reg_rd_in && reg_addr_in == OFF_DATA;

  // ==========================================================
  // receive control
  logic     hdr_no_room, collide, pad_need, abort_now, store_done;
  erb_ptr_t cur_inc;
  logic [ADDR_W:0] hdr_dist;
  assign cur_inc    = f_inc(cur_q, rx_start_q, rx_end_q);
  assign hdr_dist   = f_dist(wp_q, rel_q, rx_start_q, rx_end_q);
  assign hdr_no_room = hdr_dist != '0 &&
                       hdr_dist <= (ADDR_W+1)'(HDR_LEN);
  assign collide    = cur_inc == rel_q;
  assign pad_need   = cur_q[0];
  assign store_done = state_q == ST_HDR && hidx_q == HDR_LAST;
  assign abort_now  =
    (state_q == ST_IDLE && rx_frame_start_in &&
     (cnt_q == CNT_MAX || hdr_no_room)) ||
    (state_q == ST_DATA && rx_byte_valid_in && collide) ||
    (state_q == ST_DATA && rx_frame_end_in && pad_need && collide);

  // status vector assembled at frame end
  always_comb begin
    sv_d = '0;
    sv_d[SV_VLAN]  = type_q == TYPE_VLAN;
    sv_d[SV_CTRL]  = type_q == TYPE_CTRL;
    sv_d[SV_UNKOP] = type_q == TYPE_CTRL && opc_q != OPC_PAUSE;
    sv_d[SV_PAUSE] = type_q == TYPE_CTRL && opc_q == OPC_PAUSE &&
                     pda_q;
    sv_d[SV_DRIB]  = rx_dribble_bits_in != 3'h0;
    sv_d[SV_BCAST] = bcast_q;
    sv_d[SV_MCAST] = mcast_q && !bcast_q;
    sv_d[SV_OK]    = !rx_crc_err_in && !rx_symbol_err_in;
    sv_d[SV_LOOR]  = type_q > LEN_MAX;
    sv_d[SV_LCHK]  = type_q <= LEN_MAX &&
                     (bc_q < FRAME_OVHD ||
                      type_q != 16'(bc_q - FRAME_OVHD));
    sv_d[SV_CRC]   = rx_crc_err_in;
    sv_d[SV_CARR]  = carr_seen_q;
    sv_d[SV_LONG]  = long_seen_q || rx_long_event_in;
    sv_d[15:0]     = bc_q;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_q    <= ST_IDLE;
      cur_q      <= '0;
      next_ptr_q <= '0;
      bc_q       <= '0;
      type_q     <= '0;
      opc_q      <= '0;
      bcast_q    <= 1'b0;
      mcast_q    <= 1'b0;
      pda_q      <= 1'b0;
      hidx_q     <= '0;
      sv_q       <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (rx_frame_start_in) begin
            state_q <= abort_now ? ST_DROP : ST_DATA;
            cur_q   <= f_add(wp_q, HDR_LEN, rx_start_q, rx_end_q);
            bc_q    <= '0;
            type_q  <= '0;
            opc_q   <= '0;
            bcast_q <= 1'b1;
            mcast_q <= 1'b0;
            pda_q   <= 1'b1;
          end
        end
        ST_DATA: begin
          if (abort_now) begin
            state_q <= rx_frame_end_in ? ST_IDLE : ST_DROP;
          end else if (rx_frame_end_in) begin
            // pad byte is skipped, not written
            next_ptr_q <= pad_need ? cur_inc : cur_q;
            sv_q       <= sv_d;
            hidx_q     <= '0;
            state_q    <= ST_HDR;
          end else if (rx_byte_valid_in) begin
            cur_q <= cur_inc;
            bc_q  <= bc_q + 16'h0001;
            if (bc_q <= IDX_DA_LAST) begin
              bcast_q <= bcast_q && rx_byte_in == BYTE_ONES;
              pda_q   <= pda_q &&
                         rx_byte_in == PAUSE_DA[47 - 8*bc_q[2:0] -: 8];
            end
            if (bc_q == '0) begin
              mcast_q <= rx_byte_in[0];
            end
            if (bc_q == IDX_TYPE_HI) type_q[15:8] <= rx_byte_in;
            if (bc_q == IDX_TYPE_LO) type_q[7:0]  <= rx_byte_in;
            if (bc_q == IDX_OPC_HI)  opc_q[15:8]  <= rx_byte_in;
            if (bc_q == IDX_OPC_LO)  opc_q[7:0]   <= rx_byte_in;
          end
        end
        ST_HDR: begin
          // incoming bytes are ignored here; the gap covers 6 cycles
          hidx_q <= hidx_q + 3'h1;
          if (store_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_DROP: begin
          if (rx_frame_end_in) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // buffer write port
  logic     mem_we;
  erb_ptr_t mem_waddr;
  logic [7:0] mem_wdata;
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = cur_q;
    mem_wdata = rx_byte_in;
    if (state_q == ST_DATA && rx_byte_valid_in && !rx_frame_end_in &&
        !collide) begin
      mem_we = 1'b1;
    end else if (state_q == ST_HDR) begin
      mem_we    = 1'b1;
      mem_waddr = f_add(wp_q, hidx_q, rx_start_q, rx_end_q);
      case (hidx_q)
        3'h0:    mem_wdata = next_ptr_q[7:0];
        3'h1:    mem_wdata = f_hi(next_ptr_q);
        3'h2:    mem_wdata = sv_q[7:0];
        3'h3:    mem_wdata = sv_q[15:8];
        3'h4:    mem_wdata = sv_q[23:16];
        default: mem_wdata = sv_q[31:24];
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ==========================================================
  // window, write pointer, release pointer
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rx_start_q <= '0;
      rx_end_q   <= '1;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        OFF_ST_LO: rx_start_q <= ADDR_W'({f_hi(rx_start_q), reg_wdata_in});
        OFF_ST_HI: rx_start_q <= ADDR_W'({reg_wdata_in, rx_start_q[7:0]});
        OFF_ND_LO: rx_end_q   <= ADDR_W'({f_hi(rx_end_q), reg_wdata_in});
        OFF_ND_HI: rx_end_q   <= ADDR_W'({reg_wdata_in, rx_end_q[7:0]});
        default: ;
      endcase
    end
  end

  // configuring the window restarts the write pointer at its start
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wp_q <= '0;
    end else if (wr_st || wr_nd) begin
      wp_q <= (reg_addr_in == OFF_ST_LO)
              ? ADDR_W'({f_hi(rx_start_q), reg_wdata_in})
              : (reg_addr_in == OFF_ST_HI)
              ? ADDR_W'({reg_wdata_in, rx_start_q[7:0]}) : rx_start_q;
    end else if (store_done) begin
      wp_q <= next_ptr_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rel_q         <= '0;
      rel_lo_hold_q <= '0;
    end else if (reg_wr_in && reg_addr_in == OFF_REL_LO) begin
      rel_lo_hold_q <= reg_wdata_in;
    end else if (wr_rel_hi) begin
      rel_q <= ADDR_W'({reg_wdata_in, rel_lo_hold_q});
    end
  end

  // ==========================================================
  // host read pointer
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdptr_q   <= '0;
      read_auto_increment_en_q <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == OFF_CTRL2) begin
        read_auto_increment_en_q <= reg_wdata_in[CTRL_READ_AUTO_INCREMENT_EN_BIT];
      end
      if (wr_rdp_lo) begin
        rdptr_q <= ADDR_W'({f_hi(rdptr_q), reg_wdata_in});
      end else if (wr_rdp_hi) begin
        rdptr_q <= ADDR_W'({reg_wdata_in, rdptr_q[7:0]});
      end else if (data_rd && read_auto_increment_en_q) begin
        rdptr_q <= f_inc(rdptr_q, rx_start_q, rx_end_q);
      end
    end
  end

  // ==========================================================
  // packet count and flags
  always_comb begin
    cnt_d = cnt_q;
    if (store_done && !(dec_req && cnt_q != '0)) begin
      cnt_d = cnt_q + 8'h01;
    end else if (!store_done && dec_req && cnt_q != '0) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_q  <= '0;
      pend_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      pend_q <= cnt_d != '0;
    end
  end

  // set wins over the host clear
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      err_q <= 1'b0;
    end else if (abort_now) begin
      err_q <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == OFF_FLAGS &&
                 reg_wdata_in[FLAG_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // events since the previous stored packet
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      carr_seen_q <= 1'b0;
      long_seen_q <= 1'b0;
    end else begin
      carr_seen_q <= rx_carrier_event_in ||
                     (carr_seen_q && !store_done);
      long_seen_q <= rx_long_event_in || rx_drop_in || abort_now ||
                     (long_seen_q && !store_done);
    end
  end

  // ==========================================================
  // register read port, data valid only the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !reg_rd_in) begin
      rdata_q <= '0;
    end else begin
      case (reg_addr_in)
        OFF_DATA:   rdata_q <= mem[rdptr_q];
        OFF_RDP_LO: rdata_q <= rdptr_q[7:0];
        OFF_RDP_HI: rdata_q <= f_hi(rdptr_q);
        OFF_ST_LO:  rdata_q <= rx_start_q[7:0];
        OFF_ST_HI:  rdata_q <= f_hi(rx_start_q);
        OFF_ND_LO:  rdata_q <= rx_end_q[7:0];
        OFF_ND_HI:  rdata_q <= f_hi(rx_end_q);
        OFF_REL_LO: rdata_q <= rel_q[7:0];
        OFF_REL_HI: rdata_q <= f_hi(rel_q);
        OFF_WR_LO:  rdata_q <= wp_q[7:0];
        OFF_WR_HI:  rdata_q <= f_hi(wp_q);
        OFF_CNT:    rdata_q <= cnt_q;
        OFF_CTRL2:  rdata_q <= 8'(read_auto_increment_en_q) << CTRL_READ_AUTO_INCREMENT_EN_BIT;
        OFF_FLAGS:  rdata_q <= (8'(pend_q) << FLAG_PEND_BIT) |
                               (8'(err_q) << FLAG_ERR_BIT);
        default:    rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata_out           = rdata_q;
  assign packet_pending_flag_out = pend_q;
  assign rx_error_flag_out       = err_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_stored;
    state_q == ST_HDR && hidx_q == HDR_LAST;
  endsequence

  sequence s_full_start;
    state_q == ST_IDLE && rx_frame_start_in && cnt_q == CNT_MAX;
  endsequence

  a_wp_only_stored: assert property (
    !store_done && !wr_st && !wr_nd |=> $stable(wp_q))
    else $error("write pointer moved without a stored packet");

  a_wp_off_release: assert property (
    s_stored and (!wr_rel_hi) |=> wp_q != rel_q)
    else $error("write pointer landed on release pointer");

  // a host decrement in the same cycle legally lowers the count
  a_full_aborts: assert property (
    s_full_start and (!dec_req)
    |=> state_q == ST_DROP && err_q && cnt_q == CNT_MAX)
    else $error("packet not aborted at full count");

  a_no_release_hit: assert property (
    mem_we && state_q == ST_DATA |-> mem_waddr != rel_q)
    else $error("data written onto release location");

  a_dec_floor: assert property (
    dec_req && cnt_q == '0 && !store_done |=> cnt_q == '0 && !pend_q)
    else $error("count decremented below zero");

  a_dec_step: assert property (
    dec_req && cnt_q != '0 && !store_done
    |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("decrement did not lower count by one");

  a_store_counts: assert property (
    s_stored and (!dec_req) |=> pend_q && cnt_q == $past(cnt_q) + 8'h01)
    else $error("stored packet not counted");

  a_rel_hold: assert property (
    reg_wr_in && reg_addr_in == OFF_REL_LO |=> $stable(rel_q))
    else $error("release pointer moved on low byte write");

  a_read_auto_increment_en_wrap: assert property (
    data_rd && read_auto_increment_en_q && rdptr_q == rx_end_q && !reg_wr_in
    |=> rdptr_q == $past(rx_start_q))
    else $error("read pointer failed to wrap");

  a_even_start: assert property (
    s_stored and (!rx_start_q[0] && !wr_st && !wr_nd) |=> !wp_q[0])
    else $error("stored packet left write pointer odd");

  a_hdr_len: assert property (
    state_q == ST_IDLE && rx_frame_start_in && !abort_now
    |=> cur_q == f_add($past(wp_q), HDR_LEN, rx_start_q, rx_end_q))
    else $error("header space not reserved");
endmodule : erb_rx_buffer

// *** verification/erb_host_model.sv ***
// host model: register port master for the receive buffer
`timescale 1ns/100ps
module erb_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [3:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  import erb_pkg::*;
  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // ==========
  // bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 v = rdata_in;
  endtask : rd
  // ==========
  // host duties
  task automatic free_pkt(input logic [15:0] nxt);
    wr(OFF_REL_LO, nxt[7:0]);
    wr(OFF_REL_HI, nxt[15:8]);
    wr(OFF_CTRL2, 8'hC0);
  endtask : free_pkt
  // retry until the count is steady, pointer bytes may straddle a store
  task automatic get_wp(output logic [15:0] p);
    logic [7:0] c0, c1;
    rd(OFF_CNT, c0);
    do begin
      c1 = c0;
      rd(OFF_WR_LO, p[7:0]);
      rd(OFF_WR_HI, p[15:8]);
      rd(OFF_CNT, c0);
    end while (c0 !== c1);
  endtask : get_wp
  function automatic logic [15:0] raddr(input logic [15:0] ps, off, st, nd);
    raddr = (ps + off > nd) ? ps + off - (nd - st + 16'h0001) : ps + off;
  endfunction : raddr
endmodule : erb_host_model

// *** verification/erb_rx_buffer_tb.sv ***
// self-checking bench for the receive buffer manager
`timescale 1ns/100ps
module erb_rx_buffer_tb;
  import erb_pkg::*;
  logic ref_clk_in, reset_in, fs, fv, fe, crc, sym, car, lng, drp, wr, rd;
  logic pend, err;
  logic [2:0] drib;
  logic [3:0] addr;
  logic [7:0] rxb, wdata, rdata, d;
  logic [15:0] wp, w, n, ty, op;
  logic [47:0] da;
  logic [55:0] e;
  logic [7:0] fr[$];
  logic [15:0] nq[$];
  int bad_count, checks;
  logic [47:0] das[8] = '{48'hFFFFFFFFFFFF, 48'h020000000011, PAUSE_DA,
    PAUSE_DA, 48'h01005E000001, 48'h020000000011, 48'hFFFFFFFFFFFF,
    48'h000000000000};
  logic [15:0] tys[8] = '{16'h0800, 16'h8100, 16'h8808, 16'h8808, 16'h0000,
    16'h0001, 16'h0600, 16'h0800};
  // bits: crc, symbol, dribble count, carrier, drop, long
  logic [7:0] cfg[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h5E,
    8'h01};
  erb_rx_buffer erb_rx_buffer_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .rx_frame_start_in(fs), .rx_byte_valid_in(fv),
    .rx_byte_in(rxb), .rx_frame_end_in(fe), .rx_crc_err_in(crc),
    .rx_symbol_err_in(sym), .rx_dribble_bits_in(drib),
    .rx_carrier_event_in(car), .rx_long_event_in(lng), .rx_drop_in(drp),
    .packet_pending_flag_out(pend), .rx_error_flag_out(err));
  erb_host_model h (.clk_in(ref_clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // ==========
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  function automatic logic [31:0] esv(input logic [7:0] c);
    logic ct, bc;
    ct = ty == TYPE_CTRL;
    bc = &da;
    esv = {1'b0, ty == TYPE_VLAN, ct && op != OPC_PAUSE,
      ct && op == OPC_PAUSE && da == PAUSE_DA, ct, c[5:3] != 3'h0, bc,
      da[40] && !bc, !c[7] && !c[6], ty > LEN_MAX,
      ty <= LEN_MAX && ty != n, c[7], 1'b0, c[2], 1'b0, c[1] || c[0],
      n + FRAME_OVHD};
  endfunction : esv
  // events go one cycle ahead so they belong to the gap, not the frame
  task automatic frame(input logic [7:0] c);
    fr = {};
    for (int i = 0; i < 6; i++) fr.push_back(da[47 - 8*i -: 8]);
    repeat (6) fr.push_back(8'($urandom));
    fr.push_back(ty[15:8]);
    fr.push_back(ty[7:0]);
    fr.push_back(op[15:8]);
    fr.push_back(op[7:0]);
    repeat (n + 2) fr.push_back(8'($urandom));
    @(posedge ref_clk_in);
    {car, drp, lng} <= c[2:0];
    @(posedge ref_clk_in);
    {car, drp, lng} <= 3'b000;
    fs <= 1'b1;
    @(posedge ref_clk_in);
    fs <= 1'b0;
    foreach (fr[i]) begin
      fv <= 1'b1;
      rxb <= fr[i];
      @(posedge ref_clk_in);
    end
    fv <= 1'b0;
    fe <= 1'b1;
    {crc, sym, drib} <= c[7:3];
    @(posedge ref_clk_in);
    fe <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
  endtask : frame
  // ==========
  // scenarios
  initial begin
    {fs, fv, fe, crc, sym, car, lng, drp, drib, rxb} = '0;
    reset_in = 1'b1;
    void'($urandom(85902));
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    h.rd(OFF_ND_HI, d);
    check(d, 8'h1F);
    h.wr(OFF_CTRL2, 8'h80);
    wp = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      // last slot draws a random destination; the table entry is a filler
      da = (k == 7) ? {16'($urandom), $urandom} : das[k];
      n = 16'(2 + $urandom_range(40));
      ty = tys[k] < 16'h0002 ? n + tys[k] : tys[k];
      op = k == 3 ? 16'h0003 : OPC_PAUSE;
      frame(cfg[k]);
      h.wr(OFF_RDP_LO, wp[7:0]);
      h.wr(OFF_RDP_HI, wp[15:8]);
      wp = wp + 16'd25 + n;
      wp[0] = 1'b0;
      e = {fr[0], esv(cfg[k]), wp};
      for (int i = 0; i < 7; i++) begin
        h.rd(OFF_DATA, d);
        check(d, e[8*i +: 8]);
      end
      h.get_wp(w);
      check(w, wp);
      h.rd(OFF_CNT, d);
      check(d, k + 1);
      check(pend, 1'b1);
      nq.push_back(wp);
    end
    h.wr(OFF_REL_LO, 8'h55);
    h.rd(OFF_REL_LO, d);
    check(d, 8'h00);
    h.wr(OFF_REL_HI, 8'h00);
    h.rd(OFF_REL_LO, d);
    check(d, 8'h55);
    foreach (nq[i]) begin
      h.free_pkt(nq[i]);
      h.rd(OFF_CNT, d);
      check(d, 7 - i);
      check(pend, i < 7);
    end
    h.wr(OFF_CTRL2, 8'hC0);
    h.rd(OFF_CNT, d);
    check(d, 8'h00);
    h.wr(OFF_ND_HI, 8'h00);
    h.wr(OFF_ND_LO, 8'h3F);
    h.wr(OFF_RDP_LO, 8'h3F);
    h.wr(OFF_RDP_HI, 8'h00);
    repeat (2) h.rd(OFF_DATA, d);
    h.rd(OFF_RDP_LO, d);
    check(d, h.raddr(16'h003F, 16'h0002, 16'h0000, 16'h003F));
    h.wr(OFF_REL_LO, 8'h20);
    h.wr(OFF_REL_HI, 8'h00);
    n = 16'd30;
    frame(8'h00);
    check(err, 1'b1);
    h.get_wp(w);
    check(w, 16'h0000);
    h.wr(OFF_FLAGS, 8'h01);
    h.rd(OFF_FLAGS, d);
    check(d, 8'h00);
    h.wr(OFF_ND_HI, 8'h1F);
    h.wr(OFF_ND_LO, 8'hFF);
    h.wr(OFF_REL_LO, 8'h00);
    h.wr(OFF_REL_HI, 8'h00);
    n = 16'd2;
    repeat (255) frame(8'h00);
    frame(8'h00);
    check(err, 1'b1);
    h.rd(OFF_CNT, d);
    check(d, CNT_MAX);
    end_sim;
  end
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    bad_count++;
    end_sim;
  end
endmodule : erb_rx_buffer_tb
